// ===== core/ssp_pkg.sv
package ssp_pkg;
  // Current-limit step indices presented to the comparator
  localparam logic [1:0] LIM_195 = 2'h0;
  localparam logic [1:0] LIM_390 = 2'h1;
  localparam logic [1:0] LIM_585 = 2'h2;
  localparam logic [1:0] LIM_780 = 2'h3;
  // Converter clocks per soft-start step
  localparam int STEP_CLOCKS = 256;
  localparam int STEP_CNT_W = 8;
  localparam logic [STEP_CNT_W-1:0] STEP_CNT_RESET = 8'h00;
  localparam logic [STEP_CNT_W-1:0] STEP_CNT_LAST = 8'hff;
  // Register map
  localparam logic [3:0] REG_STATUS = 4'h0;
  localparam logic [3:0] REG_CLEAR = 4'h4;
  localparam logic [3:0] REG_ENABLE = 4'h8;
  localparam logic [3:0] REG_STATE = 4'hc;
  localparam logic [3:0] REG_CONTROL = 4'h1;
  localparam int EVT_W = 5;
  localparam int EVT_INPUT_UNDERVOLTAGE_LOCKOUT = 0;
  localparam int EVT_THERM = 1;
  localparam int EVT_SHORT = 2;
  localparam int EVT_SSDONE = 3;
  localparam int EVT_PSAVE = 4;
  localparam logic [EVT_W-1:0] EVT_RESET = 5'h00;
  localparam int CTRL_DISCHARGE_EN = 0;
  localparam int CTRL_LOCKOUT_EN = 1;
  localparam logic [1:0] CTRL_RESET = 2'h3;

  typedef enum logic [2:0] {
    SSP_OFF,
    SSP_SOFTSTART,
    SSP_RUN,
    SSP_THERMAL
  } ssp_state_t;
endpackage

// ===== core/ssp_sequencer.sv
// The implementer's own choices: the strobed register port and the register offsets.
`timescale 1ns/1ps
`default_nettype none
module ssp_sequencer #(
  parameter int CNT_W = ssp_pkg::STEP_CNT_W
) (
  // Clock, reset, enable
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic clk_en,
  // Pins and comparator flags (asynchronous)
  input wire logic conv_on_req,
  input wire logic input_undervoltage_lockout,
  input wire logic vin_below_lockout,
  input wire logic out_above_half,
  input wire logic temp_over_high,
  input wire logic temp_below_low,
  input wire logic dropout_req,
  input wire logic valley_low,
  input wire logic pwm_on_req,
  // Register port
  input wire logic [3:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  // Power stage controls
  output logic [1:0] limit_index,
  output logic limit_halved,
  output logic main_switch_on,
  output logic rect_switch_allow,
  output logic divider_connect,
  output logic control_active,
  output logic discharge_on,
  output logic psave_enter,
  output logic irq
);

  localparam int NSYNC = 9;
  // Bit positions in the synchroniser chain
  localparam int SY_EN = 0;
  localparam int SY_UV = 1;
  localparam int SY_LOCK = 2;
  localparam int SY_HALF = 3;
  localparam int SY_HOT = 4;
  localparam int SY_COOL = 5;
  localparam int SY_DROP = 6;
  localparam int SY_VALLEY = 7;
  localparam int SY_PWM = 8;

  typedef struct packed {
    logic [NSYNC-1:0] sync1;
    logic [NSYNC-1:0] sync2;
    ssp_pkg::ssp_state_t state;
    logic [CNT_W-1:0] cnt;
    logic [1:0] level;
    logic [ssp_pkg::EVT_W-1:0] status;
    logic [ssp_pkg::EVT_W-1:0] irq_en;
    logic [1:0] ctrl;
    logic [31:0] rdata;
    logic [1:0] lim;
    logic halved;
    logic main_on;
    logic rect_ok;
    logic div_on;
    logic active;
    logic dis_on;
    logic psave;
  } ssp_regs_t;

  ssp_regs_t r;
  ssp_regs_t next_r;

  // Write strobe aimed at one register offset
  function automatic logic wr_hit(
    input logic wr,
    input logic [3:0] addr,
    input logic [3:0] offset
  );
    return wr && (addr == offset);
  endfunction

  // Short-circuit halving caps the index at half of full scale
  // Never raises a lower soft-start step
  function automatic logic [1:0] capped_level(
    input logic [1:0] level,
    input logic halved
  );
    logic [1:0] idx;
    idx = level;
    if (halved && level > ssp_pkg::LIM_390)
    begin
      idx = ssp_pkg::LIM_390;
    end
    return idx;
  endfunction

  // Last clock of a soft-start step
  function automatic logic step_done(input logic [CNT_W-1:0] count);
    return count == {CNT_W{1'b1}};
  endfunction

  // States in which the power stage may switch
  function automatic logic is_running(input ssp_pkg::ssp_state_t st);
    return (st == ssp_pkg::SSP_SOFTSTART) || (st == ssp_pkg::SSP_RUN);
  endfunction

  // Read mux; write-only and unmapped offsets read as zero
  function automatic logic [31:0] read_word(
    input logic [3:0] addr,
    input ssp_regs_t cur
  );
    logic [31:0] word;
    word = 32'h0;
    case (addr)
      ssp_pkg::REG_STATUS:
      begin
        word = {27'h0, cur.status};
      end
      ssp_pkg::REG_ENABLE:
      begin
        word = {27'h0, cur.irq_en};
      end
      ssp_pkg::REG_CONTROL:
      begin
        word = {30'h0, cur.ctrl};
      end
      ssp_pkg::REG_STATE:
      begin
        word = {19'h0, cur.cnt[7:0], 1'b0, cur.lim, cur.state[1:0]};
      end
      ssp_pkg::REG_CLEAR:
      begin
        word = 32'h0;
      end
      default:
      begin
        word = 32'h0;
      end
    endcase
    return word;
  endfunction

  logic en_eff;
  logic uv;
  logic half_ok;
  logic t_hot;
  logic t_cool;
  logic drop;
  logic valley;
  logic pwm;
  logic [ssp_pkg::EVT_W-1:0] evt;

  always_comb
  begin
    next_r = r;
    next_r.sync1[SY_EN] = conv_on_req;
    next_r.sync1[SY_UV] = input_undervoltage_lockout;
    next_r.sync1[SY_LOCK] = vin_below_lockout;
    next_r.sync1[SY_HALF] = out_above_half;
    next_r.sync1[SY_HOT] = temp_over_high;
    next_r.sync1[SY_COOL] = temp_below_low;
    next_r.sync1[SY_DROP] = dropout_req;
    next_r.sync1[SY_VALLEY] = valley_low;
    next_r.sync1[SY_PWM] = pwm_on_req;
    next_r.sync2 = r.sync1;
    uv = r.sync2[SY_UV];
    half_ok = r.sync2[SY_HALF];
    t_hot = r.sync2[SY_HOT];
    t_cool = r.sync2[SY_COOL];
    drop = r.sync2[SY_DROP];
    valley = r.sync2[SY_VALLEY];
    pwm = r.sync2[SY_PWM];
    en_eff = r.sync2[SY_EN] && !(r.ctrl[ssp_pkg::CTRL_LOCKOUT_EN] && r.sync2[SY_LOCK]);
    evt = '0;

    case (r.state)
      ssp_pkg::SSP_OFF:
      begin
        next_r.cnt = ssp_pkg::STEP_CNT_RESET[CNT_W-1:0];
        next_r.level = ssp_pkg::LIM_195;
        if (en_eff && !uv && !t_hot)
        begin
          next_r.state = ssp_pkg::SSP_SOFTSTART;
        end
      end
      ssp_pkg::SSP_SOFTSTART:
      begin
        next_r.cnt = r.cnt + 1'b1;
        if (step_done(r.cnt))
        begin
          // hold at 390 without half output
          if (r.level == ssp_pkg::LIM_390 && !half_ok)
          begin
            next_r.level = r.level;
          end
          else
          begin
            next_r.level = r.level + 2'h1;
            if (r.level == ssp_pkg::LIM_585)
            begin
              next_r.state = ssp_pkg::SSP_RUN;
              evt[ssp_pkg::EVT_SSDONE] = 1'b1;
            end
          end
        end
      end
      // Full limit once the sequence has finished
      ssp_pkg::SSP_RUN:
      begin
        next_r.level = ssp_pkg::LIM_780;
      end
      // Cool-down goes via off so start-up repeats soft start
      ssp_pkg::SSP_THERMAL:
      begin
        next_r.cnt = ssp_pkg::STEP_CNT_RESET[CNT_W-1:0];
        next_r.level = ssp_pkg::LIM_195;
        if (t_cool)
        begin
          next_r.state = ssp_pkg::SSP_OFF;
        end
      end
      default:
      begin
        next_r.state = ssp_pkg::SSP_OFF;
      end
    endcase

    // Faults win over the sequence in soft start and run
    if (is_running(r.state))
    begin
      if (t_hot)
      begin
        next_r.state = ssp_pkg::SSP_THERMAL;
        next_r.cnt = ssp_pkg::STEP_CNT_RESET[CNT_W-1:0];
        next_r.level = ssp_pkg::LIM_195;
      end
      else if (!en_eff || uv)
      begin
        next_r.state = ssp_pkg::SSP_OFF;
        next_r.cnt = ssp_pkg::STEP_CNT_RESET[CNT_W-1:0];
        next_r.level = ssp_pkg::LIM_195;
      end
    end

    next_r.active = is_running(next_r.state);
    next_r.div_on = next_r.active;
    next_r.rect_ok = next_r.active && !uv && !t_hot;
    next_r.main_on = next_r.rect_ok && drop;
    next_r.dis_on = !next_r.active && r.ctrl[ssp_pkg::CTRL_DISCHARGE_EN];
    next_r.halved = next_r.active && !half_ok;
    next_r.lim = capped_level(next_r.level, next_r.halved);
    // power-save entry, not while PWM forced
    next_r.psave = next_r.active && valley && !pwm && !drop;

    // Events are one-cycle pulses into the sticky bits
    evt[ssp_pkg::EVT_INPUT_UNDERVOLTAGE_LOCKOUT] = uv && r.active;
    evt[ssp_pkg::EVT_THERM] = t_hot && r.active;
    evt[ssp_pkg::EVT_SHORT] = next_r.halved && !r.halved;
    evt[ssp_pkg::EVT_PSAVE] = next_r.psave && !r.psave;

    // Set wins over a same-cycle clear
    if (wr_hit(reg_wr, reg_addr, ssp_pkg::REG_CLEAR))
    begin
      next_r.status = (r.status & ~reg_wdata[ssp_pkg::EVT_W-1:0]) | evt;
    end
    else
    begin
      next_r.status = r.status | evt;
    end
    if (wr_hit(reg_wr, reg_addr, ssp_pkg::REG_ENABLE))
    begin
      next_r.irq_en = reg_wdata[ssp_pkg::EVT_W-1:0];
    end
    if (wr_hit(reg_wr, reg_addr, ssp_pkg::REG_CONTROL))
    begin
      next_r.ctrl = reg_wdata[1:0];
    end

    next_r.rdata = 32'h0;
    if (reg_rd)
    begin
      next_r.rdata = read_word(reg_addr, r);
    end
  end

  // Reset leaves the discharge path on, as in shutdown
  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      r <= '0;
      r.state <= ssp_pkg::SSP_OFF;
      r.ctrl <= ssp_pkg::CTRL_RESET;
      r.dis_on <= 1'b1;
    end
    else if (clk_en)
    begin
      r <= next_r;
    end
  end

  assign reg_rdata = r.rdata;
  assign limit_index = r.lim;
  assign limit_halved = r.halved;
  assign main_switch_on = r.main_on;
  assign rect_switch_allow = r.rect_ok;
  assign divider_connect = r.div_on;
  assign control_active = r.active;
  assign discharge_on = r.dis_on;
  assign psave_enter = r.psave;
  // Level output; stays high until software clears the cause
  assign irq = |(r.status & r.irq_en);

endmodule
`default_nettype wire

// ===== test/ssp_host.sv
`timescale 1ns/1ps
`default_nettype none
module ssp_host (
  // Clock, reset
  input wire logic sys_clk,
  input wire logic rst,
  // Request and pin
  input wire logic want,
  output logic conv_on_req
);
  // pin driven low from time zero
  logic q = 1'h0;
  always @(posedge sys_clk)
  begin
    q <= rst ? 1'h0 : want;
  end
  assign conv_on_req = q;
endmodule
`default_nettype wire

// ===== test/ssp_sequencer_bench.sv
`timescale 1ns/1ps
`default_nettype none
module ssp_sequencer_bench;
  logic sys_clk = 1'h0, rst = 1'h1, clk_en = 1'h1, want = 1'h0, conv_on_req;
  logic input_undervoltage_lockout = 1'h0, vin_below_lockout = 1'h0;
  logic out_above_half = 1'h0, temp_over_high = 1'h0, temp_below_low = 1'h1;
  logic dropout_req = 1'h0, valley_low = 1'h0, pwm_on_req = 1'h0;
  logic [3:0] reg_addr = 4'h0;
  logic [31:0] reg_wdata = 32'h0, reg_rdata, rd_val;
  logic reg_wr = 1'h0, reg_rd = 1'h0, limit_halved, main_switch_on, rect_switch_allow;
  logic divider_connect, control_active, discharge_on, psave_enter, irq;
  logic [1:0] limit_index;
  int n_mismatch = 0;
  int samples_checked = 0;
  ssp_host host (.*);
  ssp_sequencer dut (.*);
  initial
  begin
    forever #5 sys_clk = ~sys_clk;
  end
  task automatic close_out();
    if (n_mismatch == 0 && samples_checked > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("mismatch at %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge sys_clk);
  endtask
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'h1;
    @(posedge sys_clk);
    reg_wr <= 1'h0;
  endtask
  // Data stand only in the cycle after the read strobe
  task automatic rd(input logic [3:0] a, input logic [31:0] m, input logic [31:0] exp);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_rd <= 1'h1;
    @(posedge sys_clk);
    reg_rd <= 1'h0;
    #1 rd_val = reg_rdata & m;
    @(posedge sys_clk);
    chk(rd_val, exp);
  endtask
  task automatic till(input logic [1:0] v);
    int i;
    for (i = 0; i < 1100 && limit_index !== v; i++)
      @(posedge sys_clk);
    chk(limit_index, v);
    if (limit_index !== v)
      close_out();
  endtask
  initial
  begin
    tick(2);
    rst <= 1'h0;
    tick(6);
    chk({discharge_on, control_active}, 2'h2);
    rd(ssp_pkg::REG_CONTROL, 32'h3, 32'h3);
    rd(ssp_pkg::REG_ENABLE, 32'h1f, 32'h0);
    want <= 1'h1;
    tick(1000);
    chk({limit_halved, limit_index}, {1'h1, ssp_pkg::LIM_390});
    out_above_half <= 1'h1;
    till(ssp_pkg::LIM_780);
    rd(ssp_pkg::REG_STATUS, 32'h8, 32'h8);
    dropout_req <= 1'h1;
    tick(6);
    chk(main_switch_on, 1'h1);
    dropout_req <= 1'h0;
    valley_low <= 1'h1;
    pwm_on_req <= 1'h1;
    tick(6);
    chk(psave_enter, 1'h0);
    pwm_on_req <= 1'h0;
    tick(6);
    chk(psave_enter, 1'h1);
    valley_low <= 1'h0;
    wr(ssp_pkg::REG_ENABLE, 32'h1);
    input_undervoltage_lockout <= 1'h1;
    tick(6);
    chk({irq, rect_switch_allow, main_switch_on}, 3'h4);
    input_undervoltage_lockout <= 1'h0;
    tick(6);
    chk(limit_index, ssp_pkg::LIM_195);
    wr(ssp_pkg::REG_CLEAR, 32'h1);
    rd(ssp_pkg::REG_STATUS, 32'h1, 32'h0);
    chk(irq, 1'h0);
    temp_over_high <= 1'h1;
    temp_below_low <= 1'h0;
    tick(6);
    chk({main_switch_on, rect_switch_allow}, 2'h0);
    temp_over_high <= 1'h0;
    tick(6);
    chk(control_active, 1'h0);
    temp_below_low <= 1'h1;
    tick(8);
    chk(control_active, 1'h1);
    vin_below_lockout <= 1'h1;
    tick(6);
    chk(control_active, 1'h0);
    vin_below_lockout <= 1'h0;
    tick(6);
    chk(control_active, 1'h1);
    wr(ssp_pkg::REG_CONTROL, 32'h0);
    vin_below_lockout <= 1'h1;
    tick(6);
    chk(control_active, 1'h1);
    rd(ssp_pkg::REG_STATE, 32'h3, 32'(ssp_pkg::SSP_SOFTSTART));
    vin_below_lockout <= 1'h0;
    wr(ssp_pkg::REG_CONTROL, 32'h3);
    clk_en <= 1'h0;
    out_above_half <= 1'h0;
    tick(8);
    chk(limit_halved, 1'h0);
    clk_en <= 1'h1;
    tick(6);
    chk(limit_halved, 1'h1);
    chk(limit_index, ssp_pkg::LIM_195);
    out_above_half <= 1'h1;
    rd(4'h2, 32'hffffffff, 32'h0);
    want <= 1'h0;
    tick(7);
    chk({divider_connect, discharge_on}, 2'h1);
    close_out();
  end
endmodule
`default_nettype wire

// ===== test/ssp_sva.sv
`timescale 1ns/1ps
`default_nettype none
module ssp_sva #(
  parameter int CNT_W = 8
) (
  // Clock, reset
  input wire logic sys_clk,
  input wire logic rst,
  // Flags
  input wire logic conv_on_req,
  input wire logic input_undervoltage_lockout,
  input wire logic vin_below_lockout,
  input wire logic out_above_half,
  input wire logic temp_over_high,
  input wire logic temp_below_low,
  input wire logic dropout_req,
  // Power stage
  input wire logic [1:0] limit_index,
  input wire logic limit_halved,
  input wire logic main_switch_on,
  input wire logic rect_switch_allow,
  input wire logic divider_connect,
  input wire logic control_active,
  input wire logic discharge_on
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (rst);
  wire ok = conv_on_req && !input_undervoltage_lockout && !vin_below_lockout
    && !temp_over_high && temp_below_low;
  // Six cycles covers sync delay plus restart through the off state
  sequence held_on;
    ok [*6];
  endsequence
  a_shut_dark: assert property ((!conv_on_req) [*4] |-> discharge_on &&
    !main_switch_on && !rect_switch_allow && !divider_connect && !control_active)
    else $error("output active in shutdown");
  a_input_undervoltage_lockout_dark: assert property (input_undervoltage_lockout [*4] |->
    !main_switch_on && !rect_switch_allow) else $error("switch on in lockout");
  a_hot_dark: assert property (temp_over_high [*4] |->
    !main_switch_on && !rect_switch_allow) else $error("switch on when hot");
  a_half_cap: assert property ((!out_above_half) [*4] |->
    limit_index <= ssp_pkg::LIM_390) else $error("limit above half");
  a_step_len: assert property (limit_index == ssp_pkg::LIM_780 &&
    $past(limit_index) == ssp_pkg::LIM_585 |-> $past(limit_index, 256) == ssp_pkg::LIM_585
    && $past(limit_index, 257) != ssp_pkg::LIM_585) else $error("step length wrong");
  a_step_one: assert property (limit_index > $past(limit_index) && !$past(limit_halved)
    |-> limit_index == $past(limit_index) + 2'h1) else $error("level skipped");
  a_start_low: assert property ($rose(control_active) && !limit_halved |->
    limit_index == ssp_pkg::LIM_195) else $error("restart not at lowest level");
  a_start_up: assert property (held_on |-> control_active) else $error("no start");
  a_drop_full: assert property ((ok && dropout_req && limit_index == ssp_pkg::LIM_780)
    [*4] |-> main_switch_on) else $error("main switch off in dropout");
endmodule
bind ssp_sequencer ssp_sva #(.CNT_W(CNT_W)) u_sva (.*);
`default_nettype wire
